// ---- rtl/sdi_asi_tx_mode_control.sv ----
// Mode selection, blanking, timing source and input capture control with an AXI4-Lite slave.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - ASI select high forces ASI, ignores protocol
// - ASI select low: no ASI encoding
// - Protocol high, ASI low: SMPTE mode
// - Protocol low, ASI low: no scrambling, low latency
// - Blanking control acts only in SMPTE
// - Blanking high passes data unaltered
// - Timing select low: external H, V, F
// - Timing select high: embedded reference timing
// - Embedded timing drives H, V, F out
// - Recognise 8-bit and 10-bit reference words
// - Line buffer enable high enables FIFO path
// - FIFO enabled: capture on write clock
// - FIFO bypassed: capture on pixel clock
// - Write clear falling edge zeroes pointer, in SMPTE mode with line buffer enabled only
// - Input bit nine is MSB
module sdi_asi_tx_mode_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sdi_tx_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sdi_tx_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic asi_select,
  input wire logic protocol_mode_select,
  input wire logic blank_n,
  input wire logic timing_source_select,
  input wire logic line_buffer_en,
  input wire logic wr_clk,
  input wire logic pclk,
  input wire logic wr_ptr_clear,
  input wire logic [sdi_tx_pkg::DATA_W-1:0] din,
  input wire logic [2:0] stat_in,
  output logic [2:0] stat_out,
  output logic [2:0] stat_oe_n,
  output logic [sdi_tx_pkg::DATA_W-1:0] tx_data,
  output logic tx_valid,
  output logic asi_encode_en,
  output logic scramble_en,
  output logic low_latency,
  output logic fifo_path_en,
  output logic [sdi_tx_pkg::PTR_W-1:0] wr_ptr,
  output logic h_timing,
  output logic v_timing,
  output logic f_timing
);

  function automatic logic is_ones(input logic [sdi_tx_pkg::DATA_W-1:0] w);
    is_ones = (w[sdi_tx_pkg::DATA_W-1:2] == sdi_tx_pkg::TRS_ONES8);
  endfunction

  function automatic logic is_zero(input logic [sdi_tx_pkg::DATA_W-1:0] w);
    is_zero = (w[sdi_tx_pkg::DATA_W-1:2] == sdi_tx_pkg::TRS_ZERO8);
  endfunction

  function automatic logic pick(input sdi_tx_pkg::hvf_t t, input logic [1:0] sel);
    pick = (sel == sdi_tx_pkg::SEL_H) ? t.h : (sel == sdi_tx_pkg::SEL_V) ? t.v :
           (sel == sdi_tx_pkg::SEL_F) ? t.f : 1'b0;
  endfunction

  // The first stage is read only by the second stage.
  sdi_tx_pkg::pins_t pins_s1_q, pins_q;
  logic pclk_d_q, wr_clk_d_q, wr_clr_d_q;
  sdi_tx_pkg::mode_t mode_q;
  sdi_tx_pkg::trs_state_t trs_q, trs_d;
  sdi_tx_pkg::hvf_t hvf_emb_q, hvf_q;
  logic [sdi_tx_pkg::CTRL_W-1:0] ctrl_q;
  logic chroma_next_q, trs8_seen_q, trs10_seen_q;
  logic [sdi_tx_pkg::DATA_W-1:0] tx_data_q;
  logic tx_valid_q;
  logic [sdi_tx_pkg::PTR_W-1:0] wr_ptr_q;
  logic [2:0] stat_out_q, stat_oe_n_q;

  sdi_tx_pkg::pins_t pins_raw;
  assign pins_raw = '{asi_select, protocol_mode_select, blank_n, timing_source_select,
                      line_buffer_en, wr_clk, pclk, wr_ptr_clear, stat_in, din};

  always_ff @(posedge aclk) begin
    pins_s1_q <= pins_raw;
    pins_q <= pins_s1_q;
    pclk_d_q <= pins_q.pclk;
    wr_clk_d_q <= pins_q.wr_clk;
    wr_clr_d_q <= pins_q.wr_ptr_clear;
  end

  // Mode decode: ASI select has priority over the protocol select.
  sdi_tx_pkg::mode_t mode_d;
  assign mode_d = pins_q.asi_select ? sdi_tx_pkg::MODE_ASI :
                  pins_q.protocol_mode_select ? sdi_tx_pkg::MODE_SMPTE :
                  sdi_tx_pkg::MODE_LOW_LATENCY;

  wire smpte = (mode_q == sdi_tx_pkg::MODE_SMPTE);
  wire pclk_rise = pins_q.pclk && !pclk_d_q;
  wire wr_rise = pins_q.wr_clk && !wr_clk_d_q;
  wire wr_clr_fall = !pins_q.wr_ptr_clear && wr_clr_d_q;
  wire capture_en = ctrl_q[sdi_tx_pkg::CTRL_CAPTURE_EN_BIT];
  // A word is taken on the write clock when the FIFO path is on, else on the pixel clock.
  wire cap = capture_en && (pins_q.line_buffer_en ? wr_rise : pclk_rise);
  wire [sdi_tx_pkg::DATA_W-1:0] word = pins_q.din;
  wire word_ones = is_ones(word);
  wire is_trs = (trs_q != sdi_tx_pkg::TRS_IDLE) || word_ones;
  wire force_blank = smpte && !pins_q.blank_n && !is_trs;
  wire [sdi_tx_pkg::DATA_W-1:0] blank_word =
    chroma_next_q ? sdi_tx_pkg::CHROMA_BLANK : sdi_tx_pkg::LUMA_BLANK;
  wire [sdi_tx_pkg::DATA_W-1:0] word_out = force_blank ? blank_word : word;
  wire at_xyz = cap && (trs_q == sdi_tx_pkg::TRS_XYZ);
  wire ptr_clear = wr_clr_fall && smpte && pins_q.line_buffer_en;

  // Reference word tracker: ones, zero, zero, then the XYZ word.
  always_comb begin
    trs_d = trs_q;
    if (cap) begin
      case (trs_q)
        sdi_tx_pkg::TRS_IDLE: begin
          trs_d = word_ones ? sdi_tx_pkg::TRS_ZERO1 : sdi_tx_pkg::TRS_IDLE;
        end
        sdi_tx_pkg::TRS_ZERO1: begin
          trs_d = is_zero(word) ? sdi_tx_pkg::TRS_ZERO2 :
                  word_ones ? sdi_tx_pkg::TRS_ZERO1 : sdi_tx_pkg::TRS_IDLE;
        end
        sdi_tx_pkg::TRS_ZERO2: begin
          trs_d = is_zero(word) ? sdi_tx_pkg::TRS_XYZ : sdi_tx_pkg::TRS_IDLE;
        end
        default: begin
          trs_d = sdi_tx_pkg::TRS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= sdi_tx_pkg::MODE_LOW_LATENCY;
      trs_q <= sdi_tx_pkg::TRS_IDLE;
      hvf_emb_q <= '0;
      hvf_q <= '0;
      chroma_next_q <= 1'b1;
      tx_data_q <= '0;
      tx_valid_q <= 1'b0;
      wr_ptr_q <= sdi_tx_pkg::PTR_ZERO;
      stat_out_q <= '0;
      stat_oe_n_q <= 3'h7;
    end else begin
      mode_q <= mode_d;
      trs_q <= trs_d;
      tx_valid_q <= cap;
      if (cap) begin
        tx_data_q <= word_out;
      end
      // After a reference word the next sample is chroma.
      if (at_xyz) begin
        chroma_next_q <= 1'b1;
        hvf_emb_q <= '{word[sdi_tx_pkg::XYZ_F_BIT], word[sdi_tx_pkg::XYZ_V_BIT],
                       word[sdi_tx_pkg::XYZ_H_BIT]};
      end else if (cap && !is_trs) begin
        chroma_next_q <= !chroma_next_q;
      end
      hvf_q <= pins_q.timing_source_select ? hvf_emb_q : pins_q.stat;
      // The pins are released while the application drives external timing.
      stat_oe_n_q <= {3{!pins_q.timing_source_select}};
      stat_out_q <= {pick(hvf_q, ctrl_q[sdi_tx_pkg::CTRL_SEL2_LSB +: 2]),
                     pick(hvf_q, ctrl_q[sdi_tx_pkg::CTRL_SEL1_LSB +: 2]),
                     pick(hvf_q, ctrl_q[sdi_tx_pkg::CTRL_SEL0_LSB +: 2])};
      if (ptr_clear) begin
        wr_ptr_q <= sdi_tx_pkg::PTR_ZERO;
      end else if (cap && pins_q.line_buffer_en) begin
        wr_ptr_q <= wr_ptr_q + sdi_tx_pkg::PTR_ONE;
      end
    end
  end

  assign asi_encode_en = (mode_q == sdi_tx_pkg::MODE_ASI);
  assign scramble_en = smpte;
  assign low_latency = (mode_q == sdi_tx_pkg::MODE_LOW_LATENCY);
  assign fifo_path_en = pins_q.line_buffer_en;
  assign tx_data = tx_data_q;
  assign tx_valid = tx_valid_q;
  assign wr_ptr = wr_ptr_q;
  assign stat_out = stat_out_q;
  assign stat_oe_n = stat_oe_n_q;
  assign h_timing = hvf_q.h;
  assign v_timing = hvf_q.v;
  assign f_timing = hvf_q.f;

  // AXI4-Lite slave. Address and data are held separately so either may come first.
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [sdi_tx_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire do_read = s_axi_arvalid && !rvalid_q;
  wire wr_ctrl = do_write && (awaddr_q == sdi_tx_pkg::CTRL_OFS) && wstrb_q[0];
  wire wr_status = do_write && (awaddr_q == sdi_tx_pkg::STATUS_OFS) && wstrb_q[0];
  wire wr_mapped = (awaddr_q == sdi_tx_pkg::CTRL_OFS) || (awaddr_q == sdi_tx_pkg::STATUS_OFS);
  wire rd_ctrl = (s_axi_araddr == sdi_tx_pkg::CTRL_OFS);
  wire rd_status = (s_axi_araddr == sdi_tx_pkg::STATUS_OFS);
  wire rd_data = (s_axi_araddr == sdi_tx_pkg::DATA_OFS);
  wire trs_start = cap && (trs_q == sdi_tx_pkg::TRS_IDLE) && word_ones;
  wire trs_full = (word[1:0] == sdi_tx_pkg::TRS_LOW_ONES);

  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[sdi_tx_pkg::STAT_MODE_LSB +: 3] = mode_q;
    status_word[sdi_tx_pkg::STAT_TIMING_SRC_BIT] = pins_q.timing_source_select;
    status_word[sdi_tx_pkg::STAT_LINE_BUF_BIT] = pins_q.line_buffer_en;
    status_word[sdi_tx_pkg::STAT_TRS8_BIT] = trs8_seen_q;
    status_word[sdi_tx_pkg::STAT_TRS10_BIT] = trs10_seen_q;
    status_word[sdi_tx_pkg::STAT_HVF_LSB +: 3] = hvf_q;
    status_word[sdi_tx_pkg::STAT_PTR_LSB +: sdi_tx_pkg::PTR_W] = wr_ptr_q;
  end

  wire [31:0] rd_mux = rd_ctrl ? {25'h000_0000, ctrl_q} : rd_status ? status_word :
                       rd_data ? {22'h00_0000, tx_data_q} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bresp_q <= sdi_tx_pkg::RESP_OKAY;
      rresp_q <= sdi_tx_pkg::RESP_OKAY;
      rdata_q <= '0;
      ctrl_q <= sdi_tx_pkg::CTRL_RESET;
      trs8_seen_q <= 1'b0;
      trs10_seen_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? sdi_tx_pkg::RESP_OKAY : sdi_tx_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_q <= wdata_q[sdi_tx_pkg::CTRL_W-1:0];
      end
      if (do_read) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= (rd_ctrl || rd_status || rd_data) ? sdi_tx_pkg::RESP_OKAY :
                   sdi_tx_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
      // Sticky form flags: a new detection wins over a write-one-to-clear.
      if (trs_start && !trs_full) begin
        trs8_seen_q <= 1'b1;
      end else if (wr_status && wdata_q[sdi_tx_pkg::STAT_TRS8_BIT]) begin
        trs8_seen_q <= 1'b0;
      end
      if (trs_start && trs_full) begin
        trs10_seen_q <= 1'b1;
      end else if (wr_status && wdata_q[sdi_tx_pkg::STAT_TRS10_BIT]) begin
        trs10_seen_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_capture_plain;
    cap && !force_blank;
  endsequence

  sequence s_ones_8bit;
    trs_start && !trs_full;
  endsequence

  a_asi_priority: assert property (pins_q.asi_select |=> asi_encode_en && !scramble_en)
    else $error("ASI select did not force ASI mode");
  a_no_asi_encode: assert property (!pins_q.asi_select |=> !asi_encode_en)
    else $error("ASI encoding active with ASI select low");
  a_smpte_mode: assert property (pins_q.protocol_mode_select && !pins_q.asi_select
    |=> scramble_en && !low_latency)
    else $error("SMPTE mode not entered");
  a_low_latency: assert property (!pins_q.protocol_mode_select && !pins_q.asi_select
    |=> low_latency && !scramble_en)
    else $error("Low latency mode not entered");
  a_blank_other_mode: assert property (cap && !smpte |=> tx_data_q == $past(word))
    else $error("Data altered outside SMPTE mode");
  a_blank_levels: assert property (cap && force_blank
    |=> tx_data_q == sdi_tx_pkg::LUMA_BLANK || tx_data_q == sdi_tx_pkg::CHROMA_BLANK)
    else $error("Forced sample is not a blanking level");
  a_trs_untouched: assert property (cap && is_trs |=> tx_data_q == $past(word))
    else $error("Timing reference word was modified");
  a_pass_through: assert property (s_capture_plain ##0 pins_q.blank_n
    |=> tx_valid_q && tx_data_q == $past(word))
    else $error("Unblanked data was modified");
  a_ext_timing: assert property (!pins_q.timing_source_select
    |=> hvf_q == $past(pins_q.stat) && stat_oe_n_q == 3'h7)
    else $error("External timing not followed");
  a_emb_timing: assert property (at_xyz |=> hvf_emb_q.h == $past(word[sdi_tx_pkg::XYZ_H_BIT])
    && hvf_emb_q.f == $past(word[sdi_tx_pkg::XYZ_F_BIT]))
    else $error("Embedded timing not extracted");
  a_stat_drive: assert property (pins_q.timing_source_select [*2] |-> stat_oe_n_q == 3'h0)
    else $error("Status pins not driven in embedded mode");
  a_trs8_flag: assert property (s_ones_8bit |=> trs8_seen_q ##1 trs8_seen_q)
    else $error("8-bit reference word not flagged");
  a_fifo_capture: assert property (capture_en && pins_q.line_buffer_en && !wr_rise
    |=> !tx_valid_q)
    else $error("Capture on pixel clock with FIFO enabled");
  a_bypass_capture: assert property (capture_en && !pins_q.line_buffer_en && pclk_rise
    |=> tx_valid_q)
    else $error("Pixel clock word not captured in bypass");
  a_ptr_clear: assert property (ptr_clear |=> wr_ptr_q == sdi_tx_pkg::PTR_ZERO)
    else $error("Write pointer not cleared");

endmodule
`default_nettype wire

// ---- rtl/sdi_tx_pkg.sv ----
// Constants, field layouts and types shared by the transmitter mode and input-path control block.
package sdi_tx_pkg;

  localparam int DATA_W = 10;
  localparam int PTR_W = 11;
  localparam int ADDR_W = 4;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] DATA_OFS = 4'h8;

  // Control register fields and reset value.
  localparam int CTRL_CAPTURE_EN_BIT = 0;
  localparam int CTRL_SEL0_LSB = 1;
  localparam int CTRL_SEL1_LSB = 3;
  localparam int CTRL_SEL2_LSB = 5;
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h51;

  // Status register fields.
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_TIMING_SRC_BIT = 3;
  localparam int STAT_LINE_BUF_BIT = 4;
  localparam int STAT_TRS8_BIT = 5;
  localparam int STAT_TRS10_BIT = 6;
  localparam int STAT_HVF_LSB = 7;
  localparam int STAT_PTR_LSB = 16;

  // Multi-function pin source selector codes.
  localparam logic [1:0] SEL_H = 2'h0;
  localparam logic [1:0] SEL_V = 2'h1;
  localparam logic [1:0] SEL_F = 2'h2;

  // Video word values.
  localparam logic [DATA_W-1:0] LUMA_BLANK = 10'h040;
  localparam logic [DATA_W-1:0] CHROMA_BLANK = 10'h200;
  localparam logic [7:0] TRS_ONES8 = 8'hFF;
  localparam logic [7:0] TRS_ZERO8 = 8'h00;
  localparam logic [1:0] TRS_LOW_ONES = 2'h3;
  localparam int XYZ_F_BIT = 8;
  localparam int XYZ_V_BIT = 7;
  localparam int XYZ_H_BIT = 6;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [PTR_W-1:0] PTR_ZERO = 11'h000;
  localparam logic [PTR_W-1:0] PTR_ONE = 11'h001;

  // Every asynchronous pin that the block samples, synchronised as one vector.
  typedef struct packed {
    logic asi_select;
    logic protocol_mode_select;
    logic blank_n;
    logic timing_source_select;
    logic line_buffer_en;
    logic wr_clk;
    logic pclk;
    logic wr_ptr_clear;
    logic [2:0] stat;
    logic [DATA_W-1:0] din;
  } pins_t;

  typedef struct packed {
    logic f;
    logic v;
    logic h;
  } hvf_t;

  typedef enum logic [2:0] {
    MODE_LOW_LATENCY = 3'b001,
    MODE_SMPTE = 3'b010,
    MODE_ASI = 3'b100
  } mode_t;

  typedef enum logic [3:0] {
    TRS_IDLE = 4'b0001,
    TRS_ZERO1 = 4'b0010,
    TRS_ZERO2 = 4'b0100,
    TRS_XYZ = 4'b1000
  } trs_state_t;

endpackage

// ---- sim/video_app_source.sv ----
// Application-side model: parallel words, pixel and write clocks, external timing levels.
`timescale 1ns/10ps
`default_nettype none
module video_app_source (
  input wire logic aclk,
  input wire logic go,
  input wire logic [sdi_tx_pkg::DATA_W-1:0] word,
  input wire logic use_wr,
  input wire logic ext_drive,
  input wire logic [2:0] hvf,
  input wire logic [2:0] stat_out,
  input wire logic [2:0] stat_oe_n,
  output logic [sdi_tx_pkg::DATA_W-1:0] din,
  output logic pclk,
  output logic wr_clk,
  output logic [2:0] stat_line
);
  logic [3:0] cnt_q;
  initial begin
    cnt_q = 4'h0;
    din = '0;
    pclk = 1'b0;
    wr_clk = 1'b0;
  end
  // The word settles three cycles before its clock edge and stays well after it, because
  // the block samples these pins through two flops; the clocks stand still between words.
  always @(posedge aclk) begin
    if (cnt_q == 4'h0) begin
      if (go) begin
        din <= word;
        cnt_q <= 4'h1;
      end
    end else begin
      cnt_q <= (cnt_q == 4'ha) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'h3) begin
        wr_clk <= use_wr;
        pclk <= !use_wr;
      end
      if (cnt_q == 4'h7) begin
        wr_clk <= 1'b0;
        pclk <= 1'b0;
      end
    end
  end
  // A pin that nobody drives shows the inverse level, so a stale value cannot pass.
  assign stat_line = (~stat_oe_n & stat_out) | (stat_oe_n & (ext_drive ? hvf : ~hvf));
endmodule
`default_nettype wire

// ---- sim/test_sdi_asi_tx_mode_control.sv ----
// Self-checking testbench for the transmitter mode and input-path control block.
`timescale 1ns/10ps
`default_nettype none
module test_sdi_asi_tx_mode_control;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic asi_select, protocol_mode_select, blank_n, timing_source_select, line_buffer_en;
  logic wr_clk, pclk, wr_ptr_clear, tx_valid, asi_encode_en, scramble_en, low_latency;
  logic fifo_path_en, h_timing, v_timing, f_timing, go, use_wr;
  logic [sdi_tx_pkg::DATA_W-1:0] din, tx_data, word;
  logic [2:0] stat_in, stat_out, stat_oe_n, hvf;
  logic [sdi_tx_pkg::PTR_W-1:0] wr_ptr;
  int n_fail, n_tests;

  sdi_asi_tx_mode_control dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .asi_select, .protocol_mode_select, .blank_n,
    .timing_source_select, .line_buffer_en, .wr_clk, .pclk, .wr_ptr_clear, .din, .stat_in,
    .stat_out, .stat_oe_n, .tx_data, .tx_valid, .asi_encode_en, .scramble_en, .low_latency,
    .fifo_path_en, .wr_ptr, .h_timing, .v_timing, .f_timing
  );
  video_app_source app (
    .aclk, .go, .word, .use_wr, .ext_drive(!timing_source_select), .hvf, .stat_out,
    .stat_oe_n, .din, .pclk, .wr_clk, .stat_line(stat_in)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t %s: got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 50);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bvalid), 32'h0000_0001, "write answer");
    chk(32'(s_axi_bresp), 32'(er), "write response");
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp,
                          input logic [1:0] er);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 50);
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rvalid), 32'h0000_0001, "read answer");
    chk(32'(s_axi_rresp), 32'(er), "read response");
    if (er == sdi_tx_pkg::RESP_OKAY) chk(s_axi_rdata & mask, exp, "read data");
    @(posedge aclk);
  endtask

  // Pin order: asi, protocol, blank_n, timing source, line buffer; changed between words only.
  task automatic pins(input logic [4:0] v);
    {asi_select, protocol_mode_select, blank_n, timing_source_select, line_buffer_en} <= v;
    repeat (6) @(posedge aclk);
  endtask

  task automatic send(input logic [9:0] w, input logic wr, input logic cap, input logic [9:0] exp);
    logic seen;
    word <= w;
    use_wr <= wr;
    go <= 1'b1;
    seen = 1'b0;
    @(posedge aclk);
    go <= 1'b0;
    repeat (16) begin
      @(posedge aclk);
      if (tx_valid === 1'b1) begin
        seen = 1'b1;
        chk(32'(tx_data), 32'(exp), "word");
      end
    end
    chk(32'(seen), 32'(cap), "capture");
  endtask

  task automatic send_trs(input logic [9:0] ones, input logic [9:0] xyz);
    send(ones, 1'b0, 1'b1, ones);
    send(10'h000, 1'b0, 1'b1, 10'h000);
    send(10'h000, 1'b0, 1'b1, 10'h000);
    send(xyz, 1'b0, 1'b1, xyz);
  endtask

  task automatic t_reset();
    chk(32'(low_latency), 32'h0000_0001, "reset mode");
    chk(32'(stat_oe_n), 32'h0000_0007, "reset pins released");
    chk(32'(wr_ptr), 32'h0000_0000, "reset pointer");
    axi_read(sdi_tx_pkg::CTRL_OFS, 32'h0000_007f, 32'(sdi_tx_pkg::CTRL_RESET),
             sdi_tx_pkg::RESP_OKAY);
    axi_read(4'hc, 32'h0000_0000, 32'h0000_0000, sdi_tx_pkg::RESP_SLVERR);
  endtask

  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      pins({i[1], i[0], 3'b100});
      chk(32'(asi_encode_en), 32'(i[1]), "asi encode");
      chk(32'(scramble_en), 32'(!i[1] && i[0]), "smpte mode");
      chk(32'(low_latency), 32'(!i[1] && !i[0]), "low latency");
    end
  endtask

  task automatic t_blank();
    pins(5'b00000);
    send(10'h123, 1'b0, 1'b1, 10'h123);
    pins(5'b01000);
    send_trs(10'h3ff, 10'h2c4);
    send(10'h123, 1'b0, 1'b1, sdi_tx_pkg::CHROMA_BLANK);
    send(10'h155, 1'b0, 1'b1, sdi_tx_pkg::LUMA_BLANK);
    pins(5'b01100);
    send(10'h2ab, 1'b0, 1'b1, 10'h2ab);
    pins(5'b11000);
    send(10'h155, 1'b0, 1'b1, 10'h155);
  endtask

  task automatic t_timing();
    pins(5'b01110);
    send_trs(10'h3ff, 10'h340);
    repeat (3) @(posedge aclk);
    chk(32'({f_timing, v_timing, h_timing}), 32'h0000_0005, "embedded timing");
    chk(32'(stat_oe_n), 32'h0000_0000, "pins driven");
    chk(32'(stat_out), 32'h0000_0007, "pin levels");
    axi_write(sdi_tx_pkg::CTRL_OFS, 32'h0000_0049, sdi_tx_pkg::RESP_OKAY);
    chk(32'(stat_out), 32'h0000_0005, "pin select");
    axi_read(sdi_tx_pkg::STATUS_OFS, 32'h0000_03e8, 32'h0000_02c8, 2'h0);
    send_trs(10'h3fc, 10'h200);
    axi_read(sdi_tx_pkg::STATUS_OFS, 32'h0000_0020, 32'h0000_0020, 2'h0);
    axi_write(sdi_tx_pkg::STATUS_OFS, 32'h0000_0060, sdi_tx_pkg::RESP_OKAY);
    axi_read(sdi_tx_pkg::STATUS_OFS, 32'h0000_0060, 32'h0000_0000, 2'h0);
  endtask

  task automatic t_external();
    hvf <= 3'b010;
    pins(5'b01100);
    // The external levels reach the pins only after release, then cross two synchroniser flops and hvf_q.
    repeat (2) @(posedge aclk);
    chk(32'(stat_oe_n), 32'h0000_0007, "pins released");
    chk(32'({f_timing, v_timing, h_timing}), 32'h0000_0002, "external timing");
  endtask

  task automatic t_fifo();
    pins(5'b01101);
    chk(32'(fifo_path_en), 32'h0000_0001, "fifo path");
    send(10'h101, 1'b1, 1'b1, 10'h101);
    send(10'h102, 1'b0, 1'b0, 10'h102);
    chk(32'(wr_ptr), 32'(sdi_tx_pkg::PTR_ONE), "pointer step");
    wr_ptr_clear <= 1'b1;
    repeat (6) @(posedge aclk);
    wr_ptr_clear <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(32'(wr_ptr), 32'h0000_0000, "pointer clear");
    pins(5'b01100);
    send(10'h3a5, 1'b0, 1'b1, 10'h3a5);
    send(10'h0f0, 1'b1, 1'b0, 10'h0f0);
    chk(32'(wr_ptr), 32'h0000_0000, "pointer idle");
  endtask

  task automatic t_regs();
    axi_write(sdi_tx_pkg::CTRL_OFS, 32'h0000_0050, sdi_tx_pkg::RESP_OKAY);
    axi_read(sdi_tx_pkg::CTRL_OFS, 32'h0000_007f, 32'h0000_0050, sdi_tx_pkg::RESP_OKAY);
    send(10'h0aa, 1'b0, 1'b0, 10'h0aa);
    axi_write(sdi_tx_pkg::CTRL_OFS, 32'(sdi_tx_pkg::CTRL_RESET), sdi_tx_pkg::RESP_OKAY);
    axi_write(sdi_tx_pkg::DATA_OFS, 32'h0000_0000, sdi_tx_pkg::RESP_SLVERR);
    axi_write(4'hc, 32'h0000_0000, sdi_tx_pkg::RESP_SLVERR);
    axi_read(sdi_tx_pkg::DATA_OFS, 32'h0000_03ff, 32'h0000_03a5, sdi_tx_pkg::RESP_OKAY);
  endtask

  initial begin
    n_fail = 0;
    n_tests = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {asi_select, protocol_mode_select, timing_source_select, line_buffer_en} = '0;
    blank_n = 1'b1;
    wr_ptr_clear = 1'b0;
    go = 1'b0;
    use_wr = 1'b0;
    word = '0;
    hvf = 3'b000;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_modes();
    t_blank();
    t_timing();
    t_external();
    t_fifo();
    t_regs();
    report_and_stop();
  end

  // The whole sequence needs well under 2,000 cycles.
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    $display("BAD t=%0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
